/* channel_mode_bits_defs.svh */
/*
  Register offsets, field positions, reset values and timing counts for the
  CAN channel mode and wake control block.
  Assumes a 32-bit classic Wishbone slave with word-aligned registers.
*/
`ifndef CHANNEL_MODE_BITS_DEFS_SVH
`define CHANNEL_MODE_BITS_DEFS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define REG_CTRL_OFS    8'h00
`define REG_STATUS_OFS  8'h04

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define CTRL_MODE_LSB   0
`define CTRL_FLASH_BIT  2
`define CTRL_WDWK_BIT   3
`define CTRL_RESET      32'h0000_0000

// ----------------------------------------------------------------------------
// Status register fields (write one to clear flags)
// ----------------------------------------------------------------------------
`define ST_WAKE_BIT     0
`define ST_FAIL_BIT     1
`define ST_UV_BIT       2
`define ST_TXTO_BIT     3
`define ST_ARMED_BIT    4

// ----------------------------------------------------------------------------
// Timing defaults in clock cycles
// ----------------------------------------------------------------------------
`define EN_DELAY_CYC    16'd100
`define WAKE1_CYC       16'd25
`define WAKE2_CYC       16'd250
`define TXD_TO_CYC      16'd2000
`define BUS_TO_CYC      16'd2000

`endif

/* channel_mode_bits_pkg.sv */
/*
  Types shared by the CAN channel mode and wake control block.
  Assumes channel_mode_bits_defs.svh supplies the numeric constants.
*/
package channel_mode_bits_pkg;

  // Channel mode bits encoding
  typedef enum logic [1:0] {
    MODE_OFF  = 2'h0,
    MODE_WAKE = 2'h1,
    MODE_RXO  = 2'h2,
    MODE_NORM = 2'h3
  } can_mode_type;

  // Chip operating modes, one-hot
  typedef enum logic [5:0] {
    CHIP_INIT    = 6'h01,
    CHIP_NORMAL  = 6'h02,
    CHIP_STOP    = 6'h04,
    CHIP_SLEEP   = 6'h08,
    CHIP_RESTART = 6'h10,
    CHIP_FAILSAFE = 6'h20
  } chip_mode_type;

  // Wake detector states, one-hot
  typedef enum logic [4:0] {
    WK_IDLE  = 5'h01,
    WK_DOM1  = 5'h02,
    WK_REC   = 5'h04,
    WK_DOM2  = 5'h08,
    WK_DONE  = 5'h10
  } wake_state_type;

  // Pin-side outputs
  typedef struct packed {
    logic drive_dom;
    logic drive_en;
    logic bias_half;
    logic slope_bypass;
    logic rx_data_out;
    logic interrupt_out_n;
  } pin_out_type;

  // Requests toward the chip mode controller
  typedef struct packed {
    logic goto_restart;
    logic watchdog_enable;
    logic wake_status_a;
    logic wake_status_b;
  } sys_out_type;

  // Whole module state
  typedef struct packed {
    can_mode_type   mode;
    logic           slope_flash;
    logic           wd_on_wake;
    logic           wake_flag;
    logic           fail_flag;
    logic           uv_flag;
    logic           txto_active;
    logic           armed;
    logic           rx_wake_low;
    wake_state_type wk;
    logic [15:0]    wk_cnt;
    logic [15:0]    en_cnt;
    logic           en_done;
    logic           tx_blocked;
    logic [15:0]    txd_cnt;
    logic [15:0]    bus_cnt;
    logic [1:0]     tx_sync;
    logic [1:0]     bus_sync;
    logic [1:0]     uv_sync;
    chip_mode_type  chip_prev;
    logic           ack;
    logic [31:0]    rdata;
    pin_out_type    pins;
    sys_out_type    sys;
  } state_type;

endpackage

/* can_transceiver_mode_wake_control.sv */
/*
  Mode, wake detection and supervision logic of one CAN transceiver channel.
  Assumes a classic Wishbone master on the same clock, chip mode given by the
  chip mode controller on the same clock, and bus, transmit and undervoltage
  levels arriving asynchronously from pins or the analog front end.
*/
// The Wishbone interface to the registers and the placing of the registers were chosen for this implementation.
//
// Summary of operation
// - Reset enters off mode: driver off, bus undriven, wake ignored.
// - Off mode can be selected in any chip mode.
// - Normal mode acts only in chip normal, or init with development mode.
// - In normal mode the bus follows the transmit data input.
// - A dominant level present during the enable delay is not transmitted.
// - Slope bypass bit disables symmetric slope control for faster rates.
// - In normal mode the received bus level appears on receive data.
// - Receive-only: driver off, receive on, in chip normal and stop.
// - Wake-capable mode usable in stop/sleep/restart/normal; forced in fail-safe.
// - Wake pattern: two long dominant phases split by a short recessive.
// - After a wake, receive data stays low until the mode changes.
// - After a wake, mode bits still read wake-capable; no new wake until rearmed.
// - Rearm by mode toggle, or by entering chip stop, sleep or fail-safe.
// - Rearming never depends on clearing the wake flag.
// - Wake in stop or normal: interrupt low, status set, receive data low.
// - Wake in stop with watchdog-on-wake set enables the watchdog.
// - Wake in sleep, restart or fail-safe requests restart, no interrupt.
// - Transmit dominant too long: driver off, receive-only, fail flag set.
// - Driver returns when transmit input recessive; mode bits unchanged.
// - Bus dominant too long in any mode sets the fail flag.
// - Low supply in normal or receive-only sets flag and disables driver.
`timescale 1ns/1ps
`include "channel_mode_bits_defs.svh"

module can_transceiver_mode_wake_control
  import channel_mode_bits_pkg::*;
#(
  parameter logic [15:0] EN_DELAY = `EN_DELAY_CYC,
  parameter logic [15:0] WAKE1    = `WAKE1_CYC,
  parameter logic [15:0] WAKE2    = `WAKE2_CYC,
  parameter logic [15:0] TXD_TO   = `TXD_TO_CYC,
  parameter logic [15:0] BUS_TO   = `BUS_TO_CYC
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Wishbone slave
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic [31:0]        wb_dat_o,
  output logic               wb_ack_o,
  // Chip context
  input  wire chip_mode_type chip_mode_i,
  input  wire logic          dev_mode_i,
  // Controller and bus side (asynchronous levels)
  input  wire logic          tx_data_in_i,
  input  wire logic          bus_dominant_i,
  input  wire logic          supply_low_i,
  // Pin side outputs
  output pin_out_type        pins_o,
  // Chip controller side outputs
  output sys_out_type        sys_o
);

  state_type q, d;

  // --------------------------------------------------------------------------
  // Helper terms
  // --------------------------------------------------------------------------
  logic tx_dom, bus_dom, uv, chip_norm, norm_ok, rxo_ok, wake_mode, mode_change;
  logic entering_rearm, wake_evt, acc, wr, ctrl_hit, st_hit, drv_ok;

  assign tx_dom    = ~q.tx_sync[1];
  assign bus_dom   = q.bus_sync[1];
  assign uv        = q.uv_sync[1];
  assign chip_norm = (chip_mode_i == CHIP_NORMAL);
  assign norm_ok   = chip_norm || (chip_mode_i == CHIP_INIT && dev_mode_i);
  assign rxo_ok    = chip_norm || (chip_mode_i == CHIP_STOP);
  // Fail-safe forces wake-capable whatever the mode bits say
  assign wake_mode = (q.mode == MODE_WAKE) || (chip_mode_i == CHIP_FAILSAFE);
  assign entering_rearm = (chip_mode_i != q.chip_prev) &&
                          (chip_mode_i == CHIP_STOP || chip_mode_i == CHIP_SLEEP ||
                           chip_mode_i == CHIP_FAILSAFE);
  assign acc      = wb_cyc_i && wb_stb_i && !q.ack;
  assign wr       = acc && wb_we_i && wb_sel_i[0];
  assign ctrl_hit = (wb_adr_i == `REG_CTRL_OFS);
  assign st_hit   = (wb_adr_i == `REG_STATUS_OFS);
  assign mode_change = wr && ctrl_hit &&
                       (can_mode_type'(wb_dat_i[`CTRL_MODE_LSB +: 2]) != q.mode);
  // Gated by the mode so a stale detector state cannot raise a wake after leaving it
  assign wake_evt = (q.wk == WK_DOM2) && bus_dom && (q.wk_cnt >= WAKE1) &&
                    q.armed && wake_mode;
  assign drv_ok   = (q.mode == MODE_NORM) && norm_ok && q.en_done &&
                    !q.txto_active && !uv;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    d = q;
    d.ack      = acc;
    d.tx_sync  = {q.tx_sync[0], tx_data_in_i};
    d.bus_sync = {q.bus_sync[0], bus_dominant_i};
    d.uv_sync  = {q.uv_sync[0], supply_low_i};
    d.chip_prev = chip_mode_i;
    d.sys.goto_restart    = 1'b0;
    d.sys.watchdog_enable = 1'b0;

    // Register reads; unmapped addresses read as zero
    d.rdata = 32'h0000_0000;
    if (ctrl_hit) begin
      d.rdata[`CTRL_MODE_LSB +: 2] = q.mode;
      d.rdata[`CTRL_FLASH_BIT]     = q.slope_flash;
      d.rdata[`CTRL_WDWK_BIT]      = q.wd_on_wake;
    end else if (st_hit) begin
      d.rdata[`ST_WAKE_BIT]  = q.wake_flag;
      d.rdata[`ST_FAIL_BIT]  = q.fail_flag;
      d.rdata[`ST_UV_BIT]    = q.uv_flag;
      d.rdata[`ST_TXTO_BIT]  = q.txto_active;
      d.rdata[`ST_ARMED_BIT] = q.armed;
    end

    // Mode and option writes; any mode may be chosen at any time
    if (wr && ctrl_hit) begin
      d.mode        = can_mode_type'(wb_dat_i[`CTRL_MODE_LSB +: 2]);
      d.slope_flash = wb_dat_i[`CTRL_FLASH_BIT];
      d.wd_on_wake  = wb_dat_i[`CTRL_WDWK_BIT];
    end
    // Write one clears flags; a same-cycle event below still wins
    if (wr && st_hit) begin
      if (wb_dat_i[`ST_WAKE_BIT]) d.wake_flag = 1'b0;
      if (wb_dat_i[`ST_FAIL_BIT]) d.fail_flag = 1'b0;
      if (wb_dat_i[`ST_UV_BIT])   d.uv_flag   = 1'b0;
    end

    // Rearm on a mode toggle or a chip low-power entry, not on flag clear
    if (mode_change || entering_rearm) begin
      d.armed = 1'b1;
      d.wk    = WK_IDLE;
    end

    // Enable delay restarts whenever normal mode is (re)entered
    if (q.mode != MODE_NORM || !norm_ok) begin
      d.en_cnt     = 16'h0000;
      d.en_done    = 1'b0;
      d.tx_blocked = 1'b0;
    end else if (!q.en_done) begin
      d.en_cnt = q.en_cnt + 16'h0001;
      if (tx_dom) d.tx_blocked = 1'b1;
      if (q.en_cnt + 16'h0001 >= EN_DELAY) d.en_done = 1'b1;
    end else if (!tx_dom) begin
      d.tx_blocked = 1'b0;
    end

    // Transmit dominant time-out in normal mode
    if (q.mode == MODE_NORM && norm_ok && tx_dom) begin
      if (q.txd_cnt < TXD_TO) d.txd_cnt = q.txd_cnt + 16'h0001;
      else begin
        d.txto_active = 1'b1;
        d.fail_flag   = 1'b1;
      end
    end else begin
      d.txd_cnt     = 16'h0000;
      d.txto_active = 1'b0;
    end

    // Bus dominant clamping, any mode
    if (bus_dom) begin
      if (q.bus_cnt < BUS_TO) d.bus_cnt = q.bus_cnt + 16'h0001;
      else d.fail_flag = 1'b1;
    end else begin
      d.bus_cnt = 16'h0000;
    end

    // Supply undervoltage in the active modes
    if (uv && (q.mode == MODE_NORM || q.mode == MODE_RXO)) d.uv_flag = 1'b1;

    // Wake pattern detector
    if (!wake_mode || !q.armed) begin
      d.wk     = WK_IDLE;
      d.wk_cnt = 16'h0000;
    end else begin
      case (q.wk)
        WK_IDLE: begin
          d.wk_cnt = 16'h0000;
          if (bus_dom) d.wk = WK_DOM1;
        end
        WK_DOM1: begin
          d.wk_cnt = q.wk_cnt + 16'h0001;
          if (!bus_dom) begin
            d.wk     = (q.wk_cnt >= WAKE1) ? WK_REC : WK_IDLE;
            d.wk_cnt = 16'h0000;
          end
        end
        WK_REC: begin
          d.wk_cnt = q.wk_cnt + 16'h0001;
          if (bus_dom) begin
            d.wk     = WK_DOM2;
            d.wk_cnt = 16'h0000;
          end else if (q.wk_cnt >= WAKE2) begin
            d.wk = WK_IDLE;
          end
        end
        WK_DOM2: begin
          d.wk_cnt = q.wk_cnt + 16'h0001;
          if (!bus_dom) begin
            d.wk     = WK_IDLE;
            d.wk_cnt = 16'h0000;
          end
        end
        WK_DONE: d.wk = WK_DONE;
        default: d.wk = WK_IDLE;
      endcase
      if (wake_evt) begin
        d.wk        = WK_DONE;
        d.armed     = 1'b0;
        d.wake_flag = 1'b1;
        case (chip_mode_i)
          CHIP_STOP, CHIP_NORMAL: begin
            d.sys.wake_status_a = 1'b1;
            d.sys.wake_status_b = 1'b1;
            if (chip_mode_i == CHIP_STOP && q.wd_on_wake)
              d.sys.watchdog_enable = 1'b1;
          end
          default: begin
            d.sys.goto_restart  = 1'b1;
            d.sys.wake_status_a = 1'b1;
          end
        endcase
      end
    end

    // Interrupt: low after a stop or normal wake, released by the flag clear
    d.pins.interrupt_out_n = q.pins.interrupt_out_n;
    if (wake_evt && (chip_mode_i == CHIP_STOP || chip_mode_i == CHIP_NORMAL))
      d.pins.interrupt_out_n = 1'b0;
    else if (wr && st_hit && wb_dat_i[`ST_WAKE_BIT])
      d.pins.interrupt_out_n = 1'b1;
    if (wr && st_hit && wb_dat_i[`ST_WAKE_BIT]) begin
      d.sys.wake_status_a = 1'b0;
      d.sys.wake_status_b = 1'b0;
    end

    // Pin drive: driver only in effective normal mode after the delay
    d.pins.drive_en     = drv_ok;
    d.pins.drive_dom    = drv_ok && tx_dom && !q.tx_blocked;
    d.pins.bias_half    = (q.mode == MODE_NORM && norm_ok) ||
                          (q.mode == MODE_RXO && rxo_ok);
    d.pins.slope_bypass = q.slope_flash;
    // Receive data: bus level in active modes, held low from a wake until software
    // writes another mode; a chip-mode rearm alone does not release it
    if (mode_change) d.rx_wake_low = 1'b0;
    if (wake_evt) d.rx_wake_low = 1'b1;
    if (q.rx_wake_low || wake_evt)
      d.pins.rx_data_out = 1'b0;
    else if ((q.mode == MODE_NORM && norm_ok) || (q.mode == MODE_RXO && rxo_ok))
      d.pins.rx_data_out = !bus_dom;
    else
      d.pins.rx_data_out = 1'b1;
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q                      <= '0;
      q.mode                 <= MODE_OFF;
      q.armed                <= 1'b1;
      q.wk                   <= WK_IDLE;
      q.tx_sync              <= 2'h3;
      q.chip_prev            <= CHIP_INIT;
      q.pins.rx_data_out     <= 1'b1;
      q.pins.interrupt_out_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs come straight from the state register
  assign wb_dat_o = q.rdata;
  assign wb_ack_o = q.ack;
  assign pins_o   = q.pins;
  assign sys_o    = q.sys;

endmodule

/* can_mode_monitor.sv */
/*
  Checker for the CAN channel mode and wake block; watches its top ports only.
  Assumes one clock domain and the short counts that the bench sets.
*/
`timescale 1ns/1ps
`include "channel_mode_bits_defs.svh"
module can_mode_monitor
  import channel_mode_bits_pkg::*;
#(
  parameter logic [15:0] TXD_TO = 16'd20
) (
  // Clock and reset
  input wire logic          clk_i,
  input wire logic          rst_i,
  // Register bus
  input wire logic          wb_cyc_i,
  input wire logic          wb_stb_i,
  input wire logic          wb_we_i,
  input wire logic [7:0]    wb_adr_i,
  input wire logic [31:0]   wb_dat_o,
  input wire logic          wb_ack_o,
  // Chip context and line inputs
  input wire chip_mode_type chip_mode_i,
  input wire logic          tx_data_in_i,
  input wire logic          supply_low_i,
  // Outputs under watch
  input wire pin_out_type   pins_o,
  input wire sys_out_type   sys_o
);
  // ---------------------------------------------------------------------------
  // Helper logic
  // ---------------------------------------------------------------------------
  logic [15:0] txlow_q;
  logic [15:0] txlow_d;

  // Dominant run length on the transmit input; saturates so it never wraps
  always_comb begin
    txlow_d = 16'h0000;
    if (!tx_data_in_i) begin
      txlow_d = (txlow_q == 16'hFFFF) ? txlow_q : txlow_q + 16'h0001;
    end
  end

  // Register the run length
  always_ff @(posedge clk_i) begin
    txlow_q <= rst_i ? 16'h0000 : txlow_d;
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  AST_ACK_NEXT: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  AST_ACK_PULSE: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  AST_UNMAPPED_ZERO: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i != `REG_CTRL_OFS && wb_adr_i != `REG_STATUS_OFS
    |-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
  AST_RESET_STATE: assert property (
    $fell(rst_i) |-> !pins_o.drive_en && pins_o.rx_data_out && pins_o.interrupt_out_n)
    else $error("outputs not idle after reset");
  AST_CHIP_GATES_DRIVER: assert property (
    (chip_mode_i inside {CHIP_STOP, CHIP_SLEEP, CHIP_RESTART, CHIP_FAILSAFE})[*3]
    |-> !pins_o.drive_en) else $error("driver on outside normal chip mode");
  AST_TX_RECESSIVE: assert property (
    tx_data_in_i[*4] |-> !pins_o.drive_dom) else $error("dominant without transmit");
  AST_TXD_TIMEOUT: assert property (
    txlow_q > TXD_TO + 16'd4 |-> !(pins_o.drive_en && pins_o.drive_dom))
    else $error("transmit time-out missed");
  AST_UV_DRIVER: assert property (
    supply_low_i[*5] |-> !pins_o.drive_en) else $error("driver on at low supply");
  AST_NO_INT_LOWPOWER: assert property (
    (chip_mode_i inside {CHIP_SLEEP, CHIP_RESTART, CHIP_FAILSAFE})[*3]
    |-> !$fell(pins_o.interrupt_out_n)) else $error("interrupt in low power wake");
  AST_WD_STOP_ONLY: assert property (
    (chip_mode_i != CHIP_STOP)[*3] |-> !sys_o.watchdog_enable)
    else $error("watchdog enable outside stop");
  AST_INT_WITH_RX: assert property (
    $fell(pins_o.interrupt_out_n) |-> ##[0:3] !pins_o.rx_data_out)
    else $error("interrupt without receive low");
endmodule

bind can_transceiver_mode_wake_control can_mode_monitor #(.TXD_TO(TXD_TO)) mon (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
  .chip_mode_i, .tx_data_in_i, .supply_low_i, .pins_o, .sys_o);

/* can_ctrl_model.sv */
/*
  Model of the protocol controller that feeds the channel's transmit input.
  Assumes the bench calls send and keeps to its cycle counts.
*/
`timescale 1ns/1ps
module can_ctrl_model (
  // Clock
  input  wire logic clk_i,
  // Receive level from the channel
  input  wire logic rx_data_i,
  // Transmit level toward the channel, low is dominant
  output logic      tx_data_o
);
  // Recessive from the start, so enabling never sees a stray dominant
  initial tx_data_o = 1'b1;

  // Hold one level for a number of cycles, changed just after an edge
  task automatic send(input logic lvl, input int cyc);
    @(posedge clk_i);
    tx_data_o <= lvl;
    repeat (cyc - 1) @(posedge clk_i);
  endtask
endmodule

/* can_transceiver_mode_wake_control_tb_top.sv */
/*
  Self-checking bench for the CAN channel mode and wake block.
  Assumes the checker and the controller model are compiled before it.
*/
`timescale 1ns/1ps
`include "channel_mode_bits_defs.svh"
module can_transceiver_mode_wake_control_tb_top;
  import channel_mode_bits_pkg::*;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  localparam int END = 4;
  localparam int WK2 = 10;
  localparam int TXT = 20;
  localparam int BST = 20;
  localparam logic [7:0] CT = `REG_CTRL_OFS;
  localparam logic [7:0] ST = `REG_STATUS_OFS;
  logic          clk_i = 1'b0;
  logic          rst_i = 1'b1;
  logic          wb_cyc_i = 1'b0;
  logic          wb_stb_i = 1'b0;
  logic          wb_we_i = 1'b0;
  logic [7:0]    wb_adr_i = 8'h00;
  logic [3:0]    wb_sel_i = 4'h0;
  logic [31:0]   wb_dat_i = 32'h0;
  logic [31:0]   wb_dat_o;
  logic          wb_ack_o;
  chip_mode_type chip_mode_i = CHIP_NORMAL;
  logic          dev_mode_i = 1'b0;
  logic          tx_data_in_i;
  logic          bus_ext = 1'b0;
  logic          bus_dominant_i;
  logic          supply_low_i = 1'b0;
  pin_out_type   pins_o;
  sys_out_type   sys_o;
  logic [31:0]   rd;
  logic          s;
  int            num_errors = 0;
  int            total_checks = 0;
  int            cycles = 0;
  int            wd_cnt = 0;
  int            gr_cnt = 0;
  int            w0;
  chip_mode_type cm [3] = '{CHIP_INIT, CHIP_NORMAL, CHIP_STOP};
  int            pat [4][4] = '{'{2, 3, 6, 0}, '{6, 15, 6, 0}, '{6, 3, 2, 0}, '{6, 3, 6, 1}};

  // Bus is dominant when another node or our own driver pulls it
  assign bus_dominant_i = bus_ext | (pins_o.drive_en & pins_o.drive_dom);

  can_transceiver_mode_wake_control #(.EN_DELAY(16'd4), .WAKE1(16'd3), .WAKE2(16'd10),
    .TXD_TO(16'd20), .BUS_TO(16'd20)) DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .chip_mode_i,
    .dev_mode_i, .tx_data_in_i, .bus_dominant_i, .supply_low_i, .pins_o, .sys_o);
  can_ctrl_model ctrl (.clk_i, .rx_data_i(pins_o.rx_data_out), .tx_data_o(tx_data_in_i));

  always #20 clk_i = ~clk_i;

  // Count pulses and cycles; the cycle ceiling cuts a hang short
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (sys_o.watchdog_enable === 1'b1) wd_cnt <= wd_cnt + 1;
    if (sys_o.goto_restart === 1'b1) gr_cnt <= gr_cnt + 1;
    if (cycles == 20000) begin
      num_errors++;
      summarize();
    end
  end

  // ---------------------------------------------------------------------------
  // Tasks and reference model
  // ---------------------------------------------------------------------------
  function automatic logic drv(int m, int c, int d);
    return m == 3 && (c == 1 || (c == 0 && d == 1));
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  // One classic cycle; released only at the edge that samples ack high
  task automatic bus_op(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    if (n >= 40) begin
      num_errors++;
      summarize();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // Two dominant phases split by a recessive gap, then a long quiet tail
  task automatic wake_pattern(input int d1, input int r, input int d2);
    @(posedge clk_i);
    bus_ext <= 1'b1;
    repeat (d1) @(posedge clk_i);
    bus_ext <= 1'b0;
    repeat (r) @(posedge clk_i);
    bus_ext <= 1'b1;
    repeat (d2) @(posedge clk_i);
    bus_ext <= 1'b0;
    idle(WK2 + 5);
  endtask

  task automatic summarize;
    $display("Checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    void'($urandom(32'h8A8B));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    idle(0);
    chk(pins_o, 32'h3);
    bus_op(1'b0, CT, 32'h0);
    chk(rd, `CTRL_RESET);
    bus_op(1'b1, 8'h08, 32'hFF);
    bus_op(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0);
    for (int c = 0; c < 3; c++) begin
      for (int d = 0; d < 2; d++) begin
        for (int m = 0; m < 4; m++) begin
          s = 1'($urandom % 2);
          @(posedge clk_i);
          chip_mode_i <= cm[c];
          dev_mode_i  <= d[0];
          bus_op(1'b1, CT, {28'h0, 1'b0, s, m[1:0]});
          idle(END + 5);
          chk(pins_o.drive_en, drv(m, c, d));
          if (drv(m, c, d)) chk(pins_o.slope_bypass, s);
          chk(pins_o.bias_half, drv(m, c, d) || (m == 2 && c != 0));
          bus_op(1'b0, CT, 32'h0);
          chk(rd[2:0], {s, m[1:0]});
        end
      end
    end
    // Normal traffic, then a dominant held through the enable delay
    @(posedge clk_i);
    chip_mode_i <= CHIP_NORMAL;
    bus_op(1'b1, CT, 32'h3);
    idle(END + 4);
    ctrl.send(1'b0, 9);
    idle(0);
    chk({pins_o.drive_dom, pins_o.rx_data_out}, 2'b10);
    bus_op(1'b1, CT, 32'h0);
    ctrl.send(1'b0, 2);
    bus_op(1'b1, CT, 32'h3);
    ctrl.send(1'b0, END + 6);
    idle(0);
    chk(pins_o.drive_dom, 1'b0);
    ctrl.send(1'b1, 4);
    ctrl.send(1'b0, 9);
    idle(0);
    chk(pins_o.drive_dom, 1'b1);
    ctrl.send(1'b0, TXT + 8);
    idle(0);
    chk(pins_o.drive_en & pins_o.drive_dom, 1'b0);
    bus_op(1'b0, ST, 32'h0);
    chk(rd[3:1], 3'b101);
    ctrl.send(1'b1, 6);
    idle(0);
    chk(pins_o.drive_en, 1'b1);
    bus_op(1'b0, ST, 32'h0);
    chk(rd[3], 1'b0);
    bus_op(1'b0, CT, 32'h0);
    chk(rd[1:0], 2'h3);
    bus_op(1'b1, ST, 32'h7);
    @(posedge clk_i);
    supply_low_i <= 1'b1;
    idle(6);
    chk(pins_o.drive_en, 1'b0);
    bus_op(1'b0, ST, 32'h0);
    chk(rd[2], 1'b1);
    @(posedge clk_i);
    supply_low_i <= 1'b0;
    idle(6);
    chk(pins_o.drive_en, 1'b1);
    // Off mode: clamp sets the fault, a wake pattern is ignored
    bus_op(1'b1, CT, 32'h0);
    bus_op(1'b1, ST, 32'h7);
    wake_pattern(6, 3, 6);
    @(posedge clk_i);
    bus_ext <= 1'b1;
    idle(BST + 8);
    bus_op(1'b0, ST, 32'h0);
    chk(rd[1:0], 2'b10);
    bus_op(1'b0, CT, 32'h0);
    chk(rd[1:0], 2'h0);
    @(posedge clk_i);
    bus_ext <= 1'b0;
    bus_op(1'b1, ST, 32'h7);
    // Wake in stop: bad patterns first, the valid one last
    @(posedge clk_i);
    chip_mode_i <= CHIP_STOP;
    bus_op(1'b1, CT, 32'h9);
    for (int i = 0; i < 4; i++) begin
      w0 = wd_cnt;
      wake_pattern(pat[i][0], pat[i][1], pat[i][2]);
      chk(pins_o.rx_data_out, !pat[i][3]);
      chk(wd_cnt - w0, pat[i][3]);
    end
    chk({pins_o.interrupt_out_n, sys_o.wake_status_a | sys_o.wake_status_b}, 2'b01);
    bus_op(1'b0, CT, 32'h0);
    chk(rd[1:0], 2'h1);
    w0 = wd_cnt;
    wake_pattern(6, 3, 6);
    chk(wd_cnt - w0, 0);
    @(posedge clk_i);
    chip_mode_i <= CHIP_NORMAL;
    bus_op(1'b1, ST, 32'h7);
    idle(2);
    chk({pins_o.interrupt_out_n, pins_o.rx_data_out}, 2'b10);
    // Sleep rearms by itself; the wake asks for restart with no interrupt
    @(posedge clk_i);
    chip_mode_i <= CHIP_SLEEP;
    idle(3);
    bus_op(1'b0, ST, 32'h0);
    chk(rd[4], 1'b1);
    w0 = gr_cnt;
    wake_pattern(6, 3, 6);
    chk(gr_cnt - w0, 1);
    chk({pins_o.interrupt_out_n, pins_o.rx_data_out}, 2'b10);
    bus_op(1'b1, CT, 32'h0);
    idle(4);
    chk(pins_o.rx_data_out, 1'b1);
    bus_op(1'b1, CT, 32'h1);
    bus_op(1'b0, ST, 32'h0);
    chk({rd[4], rd[0]}, 2'b11);
    summarize();
  end
endmodule
